// file: rsd_pkg.sv
// package for the register space decoder: map constants and field layout
// assumes a 28-bit internal byte address and 16-bit data words
package rsd_pkg;
  localparam int ADDR_W = 28; // internal decode address width
  localparam int DATA_W = 16; // register word width
  localparam int BLK_W = 12; // 4k register window, byte offset width
  localparam int NUM_REGS = 16; // words held in the local register file
  localparam int IDX_W = 4; // word index width
  localparam int BASE_LSB = 24; // base field low address bit
  localparam int BASE_W = 4; // base field bits 27..24
  localparam logic [BASE_W-1:0] BASE_RST = 4'h0; // base after reset
  localparam logic [23:0] WIN_TOP = 24'hfff000; // window inside 16m page
  localparam logic [BLK_W-1:0] OFS_BASE = 12'h000; // base register offset
  localparam logic [BLK_W-1:0] OFS_MAP = 12'h002; // map size control
  localparam logic [BLK_W-1:0] OFS_STAT = 12'h004; // read-only status
  localparam logic [BLK_W-1:0] OFS_WO = 12'h006; // write-only, bit 0 clears
  localparam logic [DATA_W-1:0] REG_RST = 16'h0000; // general reset value
  typedef enum logic [1:0] {
    RSD_TGT_NONE,
    RSD_TGT_REG,
    RSD_TGT_CS,
    RSD_TGT_DRAM
  } rsd_tgt_e;
endpackage

// file: rsd_mem_if.sv
// interface between the decoder and its register storage
// assumes a single clock shared by both ends
interface rsd_mem_if;
  import rsd_pkg::*;
  logic we; // one-cycle write strobe
  logic [IDX_W-1:0] idx; // word index
  logic [DATA_W-1:0] wdata; // write data
  logic [DATA_W-1:0] rdata; // registered read data
  logic byp; // read a control word instead of storage
  logic [DATA_W-1:0] byp_data; // control word to return
  modport ctl (output we, output idx, output wdata, output byp,
    output byp_data, input rdata);
  modport mem (input we, input idx, input wdata, input byp,
    input byp_data, output rdata);
endinterface

// file: rsd_regfile.sv
// small word memory that backs the general registers of the block
// assumes the caller only indexes words inside the array
module rsd_regfile
  import rsd_pkg::*;
#(
  parameter int DEPTH = NUM_REGS
) (
  input wire logic core_clk_i,
  input wire logic rst_b_i,
  rsd_mem_if.mem port
);
  logic [DATA_W-1:0] mem_reg [DEPTH]; // storage words
  logic [DATA_W-1:0] rd_reg; // registered read data
  logic [DATA_W-1:0] rd_next;

  // read data is looked up combinationally then registered; control words
  // come in on the bypass so every read leaves through the same flop
  always_comb begin
    rd_next = port.byp ? port.byp_data : mem_reg[port.idx];
  end

  // storage and read register; reset clears every word
  always_ff @(posedge core_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      rd_reg <= REG_RST;
      for (int i = 0; i < DEPTH; i++) begin
        mem_reg[i] <= REG_RST;
      end
    end else begin
      rd_reg <= rd_next;
      if (port.we) begin
        mem_reg[port.idx] <= port.wdata;
      end
    end
  end

  assign port.rdata = rd_reg;
endmodule

// file: rsd_decoder.sv
// register space decoder: places the 4k register window and arbitrates
// between registers, chip-select banks and dram on overlapping hits
// assumes a master that issues one word access per valid cycle and that
// the chip-select and dram hit lines come from same-clock decode logic
module rsd_decoder
  import rsd_pkg::*;
(
  input wire logic core_clk_i,
  input wire logic rst_b_i,
  input wire logic req_i, // one-cycle access request
  input wire logic wr_i, // high for write, low for read
  input wire logic [ADDR_W-1:0] addr_i, // byte address
  input wire logic [DATA_W-1:0] wdata_i, // write word
  input wire logic cs_hit_i, // some chip-select bank matches
  input wire logic dram_hit_i, // some dram bank matches
  output logic ack_o, // register access done
  output logic [DATA_W-1:0] rdata_o, // register read data
  output logic sel_cs_o, // chip-selects win the access
  output logic sel_dram_o, // dram wins the access
  output logic misalign_o // odd address seen on register hit
);
  rsd_mem_if mif ();

  rsd_regfile #(
    .DEPTH(NUM_REGS)
  ) u_regs (
    .core_clk_i(core_clk_i),
    .rst_b_i(rst_b_i),
    .port(mif)
  );

  logic [BASE_W-1:0] base_reg; // relocation field
  logic [BASE_W-1:0] base_next;
  logic map256_reg; // full 256m decode enabled
  logic map256_next;
  logic ack_reg; // register answer pulse
  logic ack_next;
  logic cs_reg; // chip-select grant pulse
  logic cs_next;
  logic dram_reg; // dram grant pulse
  logic dram_next;
  logic mis_reg; // odd-address flag, travels with ack
  logic mis_next;
  logic mis_seen_reg; // sticky odd-address flag shown in status
  logic mis_seen_next;
  logic mis_set; // this access is an odd register access
  logic mis_clr; // software asks to clear the sticky flag
  logic wr_hit; // register write accepted this cycle
  logic rd_hit; // register read accepted this cycle
  logic [BLK_W-1:0] ofs_word; // offset with the byte bit forced even
  logic reg_hit; // address falls in the window
  logic [BLK_W-1:0] ofs; // offset inside window
  rsd_tgt_e tgt; // winning target

  // window match; in 16m mode bits 27..24 are ignored like an alias-free
  // 24-bit master would present them, so the window stays at the top
  always_comb begin
    if (map256_reg) begin
      reg_hit = (addr_i[ADDR_W-1:BASE_LSB] == base_reg) &&
                (addr_i[BASE_LSB-1:BLK_W] == WIN_TOP[23:BLK_W]);
    end else begin
      reg_hit = (addr_i[BASE_LSB-1:BLK_W] == WIN_TOP[23:BLK_W]);
    end
    ofs = addr_i[BLK_W-1:0];
  end

  // fixed priority arbitration, only one winner responds
  always_comb begin
    if (!req_i) begin
      tgt = RSD_TGT_NONE;
    end else if (reg_hit) begin
      tgt = RSD_TGT_REG;
    end else if (cs_hit_i) begin
      tgt = RSD_TGT_CS;
    end else if (dram_hit_i) begin
      tgt = RSD_TGT_DRAM;
    end else begin
      tgt = RSD_TGT_NONE;
    end
  end

  // access qualifiers shared by the state groups below; the offset is
  // forced even so an odd byte address still reaches its whole word
  always_comb begin
    ofs_word = {ofs[BLK_W-1:1], 1'b0};
    wr_hit = (tgt == RSD_TGT_REG) && wr_i;
    rd_hit = (tgt == RSD_TGT_REG) && !wr_i;
    mis_set = (tgt == RSD_TGT_REG) && ofs[0];
    mis_clr = wr_hit && (ofs_word == OFS_WO) && wdata_i[0];
  end

  // configuration next state; decode above always used the old base, so
  // a base write is seen whole from the following cycle on
  always_comb begin
    base_next = base_reg;
    map256_next = map256_reg;
    if (wr_hit) begin
      case (ofs_word)
        OFS_BASE: begin
          base_next = wdata_i[BASE_W-1:0];
        end
        OFS_MAP: begin
          map256_next = wdata_i[0];
        end
        default: begin
          // other words leave the map alone
        end
      endcase
    end
  end

  // configuration flops; reset puts the window back at the top of 16m
  always_ff @(posedge core_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      base_reg <= BASE_RST;
      map256_reg <= 1'b0; // 16m map at power-up
    end else begin
      base_reg <= base_next;
      map256_reg <= map256_next;
    end
  end

  // answer pulses: at most one winner, one cycle after the request edge
  always_comb begin
    ack_next = 1'b0;
    cs_next = 1'b0;
    dram_next = 1'b0;
    mis_next = 1'b0;
    case (tgt)
      RSD_TGT_REG: begin
        ack_next = 1'b1; // no wait states
        mis_next = ofs[0]; // byte address flagged, still a word access
      end
      RSD_TGT_CS: begin
        cs_next = 1'b1;
      end
      RSD_TGT_DRAM: begin
        dram_next = 1'b1;
      end
      default: begin
        // nobody claims the address, nothing answers
      end
    endcase
  end

  // answer flops; each pulse stands for exactly one cycle
  always_ff @(posedge core_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      ack_reg <= 1'b0;
      cs_reg <= 1'b0;
      dram_reg <= 1'b0;
      mis_reg <= 1'b0;
    end else begin
      ack_reg <= ack_next;
      cs_reg <= cs_next;
      dram_reg <= dram_next;
      mis_reg <= mis_next;
    end
  end

  // sticky odd-address flag; a new odd access wins over a clear in the
  // same cycle, so a misuse is never lost to a racing clear
  always_comb begin
    mis_seen_next = mis_seen_reg;
    if (mis_set) begin
      mis_seen_next = 1'b1;
    end else if (mis_clr) begin
      mis_seen_next = 1'b0;
    end
  end

  // status flop
  always_ff @(posedge core_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      mis_seen_reg <= 1'b0;
    end else begin
      mis_seen_reg <= mis_seen_next;
    end
  end

  // storage port: general words go to the register file, control words
  // are fed in as a bypass so the file's output flop carries every read
  // and the read data leaves the block straight from a flip-flop
  always_comb begin
    mif.we = 1'b0;
    mif.idx = ofs[IDX_W:1]; // word index, bit 0 dropped
    mif.wdata = wdata_i;
    mif.byp = 1'b0;
    mif.byp_data = REG_RST;
    case (ofs_word)
      OFS_BASE: begin
        mif.byp = rd_hit;
        mif.byp_data = {{(DATA_W-BASE_W){1'b0}}, base_reg};
      end
      OFS_MAP: begin
        mif.byp = rd_hit;
        mif.byp_data = {{(DATA_W-1){1'b0}}, map256_reg};
      end
      OFS_STAT: begin
        mif.byp = rd_hit; // read-only, a write is acked and dropped
        mif.byp_data = {{(DATA_W-2){1'b0}}, mis_seen_reg, map256_reg};
      end
      OFS_WO: begin
        mif.byp = rd_hit; // write-only, reads back as zero
        mif.byp_data = REG_RST;
      end
      default: begin
        mif.we = wr_hit; // general read-write word
      end
    endcase
  end

  // every output is a flop: the pulses here, read data in the file
  assign ack_o = ack_reg;
  assign rdata_o = mif.rdata;
  assign sel_cs_o = cs_reg;
  assign sel_dram_o = dram_reg;
  assign misalign_o = mis_reg;
endmodule

// file: rsd_monitor.sv
// checker for the decoder: answer timing, target priority, boot window
// assumes one clock domain and the active-low async reset of the top
module rsd_monitor
  import rsd_pkg::*;
(
  input wire logic core_clk_i,
  input wire logic rst_b_i,
  input wire logic req_i,
  input wire logic wr_i,
  input wire logic [ADDR_W-1:0] addr_i,
  input wire logic cs_hit_i,
  input wire logic dram_hit_i,
  input wire logic ack_o,
  input wire logic sel_cs_o,
  input wire logic sel_dram_o,
  input wire logic misalign_o
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (!rst_b_i);
  // any write may move the window, so boot checks stop after the first
  logic wrote_reg;
  logic wrote_next;
  always_comb wrote_next = wrote_reg | (req_i & wr_i);
  always_ff @(posedge core_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) wrote_reg <= 1'b0;
    else wrote_reg <= wrote_next;
  end
  chk_idle_quiet: assert property (!req_i |=>
    !(ack_o | sel_cs_o | sel_dram_o)) else $error("answer without request");
  chk_one_target: assert property ($onehot0({ack_o, sel_cs_o,
    sel_dram_o})) else $error("two targets answered");
  chk_cs_over_dram: assert property (req_i && cs_hit_i |=>
    ack_o || sel_cs_o) else $error("chip-select lost to dram");
  chk_dram_last: assert property (req_i && dram_hit_i && !cs_hit_i |=>
    ack_o || sel_dram_o) else $error("dram hit not served");
  chk_odd_flag: assert property (misalign_o |-> ack_o)
    else $error("misalign without ack");
  chk_even_clean: assert property (req_i && !addr_i[0] |=> !misalign_o)
    else $error("misalign on even address");
  chk_boot_window: assert property (req_i && !wrote_reg &&
    addr_i[23:12] == 12'hfff |=> ack_o) else $error("boot window missed");
  chk_boot_outside: assert property (req_i && !wrote_reg &&
    addr_i[23:12] != 12'hfff |=> !ack_o) else $error("ack outside window");
endmodule
bind rsd_decoder rsd_monitor mon (.core_clk_i(core_clk_i),
  .rst_b_i(rst_b_i), .req_i(req_i), .wr_i(wr_i), .addr_i(addr_i),
  .cs_hit_i(cs_hit_i), .dram_hit_i(dram_hit_i), .ack_o(ack_o),
  .sel_cs_o(sel_cs_o), .sel_dram_o(sel_dram_o), .misalign_o(misalign_o));

// file: rsd_master.sv
// bus master model: one word access per call, one-cycle request pulse
// assumes the decoder answers exactly one cycle after the request edge
module rsd_master
  import rsd_pkg::*;
(
  input wire logic core_clk_i,
  output logic req_o,
  output logic wr_o,
  output logic [ADDR_W-1:0] addr_o,
  output logic [DATA_W-1:0] wdata_o,
  output logic cs_hit_o,
  output logic dram_hit_o
);
  timeunit 1ns;
  timeprecision 1ps;
  initial {req_o, wr_o, addr_o, wdata_o, cs_hit_o, dram_hit_o} = '0;
  // returns just after the answer edge so the caller sees the reply
  task automatic acc(input logic w, input logic [ADDR_W-1:0] a,
      input logic [DATA_W-1:0] d, input logic c, input logic m);
    @(posedge core_clk_i) #1;
    // whole 16-bit words only, no byte lanes
    {req_o, wr_o, addr_o, wdata_o, cs_hit_o, dram_hit_o} =
      {1'b1, w, a, d, c, m};
    @(posedge core_clk_i) #1;
    // released bus drops request and hit lines and shows the rest inverted, never a stale copy
    {req_o, cs_hit_o, dram_hit_o} = 3'b000;
    wr_o = ~wr_o;
    addr_o = ~addr_o;
    wdata_o = ~wdata_o;
  endtask
  // register write: one whole word, no other decode hits
  task automatic wr_word(input logic [ADDR_W-1:0] a,
      input logic [DATA_W-1:0] d);
    acc(1'b1, a, d, 1'b0, 1'b0);
  endtask
  // read with the chosen chip-select and dram decode hits
  task automatic rd_word(input logic [ADDR_W-1:0] a, input logic c,
      input logic m);
    acc(1'b0, a, '0, c, m);
  endtask
endmodule

// file: register_space_decoder_tb_top.sv
// testbench for the decoder: accesses via the master model, checked
// assumes rsd_master and the bound monitor are compiled beforehand
module register_space_decoder_tb_top
  import rsd_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic core_clk_i, rst_b_i, req, wr, cs, dr, ack, sc, sd, mis;
  logic [ADDR_W-1:0] addr;
  logic [DATA_W-1:0] wd, rd;
  int bad_count, checks;
  initial begin
    core_clk_i = 1'b0;
    forever #50 core_clk_i = ~core_clk_i;
  end
  rsd_master m (.core_clk_i(core_clk_i), .req_o(req), .wr_o(wr),
    .addr_o(addr), .wdata_o(wd), .cs_hit_o(cs), .dram_hit_o(dr));
  rsd_decoder DUT (.core_clk_i(core_clk_i), .rst_b_i(rst_b_i), .req_i(req),
    .wr_i(wr), .addr_i(addr), .wdata_i(wd), .cs_hit_i(cs), .dram_hit_i(dr),
    .ack_o(ack), .rdata_o(rd), .sel_cs_o(sc), .sel_dram_o(sd),
    .misalign_o(mis));
  task automatic chk(input logic [DATA_W-1:0] seen,
      input logic [DATA_W-1:0] exp);
    checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  // flags in order ack, chip-select, dram, misalign
  task automatic outs(input logic [3:0] e);
    chk({12'h000, ack, sc, sd, mis}, {12'h000, e});
  endtask
  task automatic rst();
    rst_b_i = 1'b0;
    repeat (12) @(posedge core_clk_i);
    #1 rst_b_i = 1'b1;
  endtask
  task automatic stop_test();
    $display("mismatches %0d of %0d checks", bad_count, checks);
    if (bad_count == 0 && checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  initial begin
    bad_count = 0;
    checks = 0;
    rst();
    m.rd_word(28'h0fff000, 1'b0, 1'b0);
    outs(4'h8);
    chk(rd, {{(DATA_W-BASE_W){1'b0}}, BASE_RST});
    // every overlap of register, chip-select and dram hits
    for (int i = 0; i < 8; i++) begin
      m.rd_word(i[0] ? 28'h5fff000 : 28'h0ffe000, i[1], i[2]);
      outs(i[0] ? 4'h8 : i[1] ? 4'h4 : i[2] ? 4'h2 : 4'h0);
    end
    m.wr_word(28'h0fff010, 16'ha5c3);
    outs(4'h8);
    m.wr_word(28'h0fff004, 16'hffff);
    m.wr_word(28'h0fff006, 16'h1234);
    m.rd_word(28'h0fff004, 1'b0, 1'b0);
    chk(rd, 16'h0000);
    m.rd_word(28'h0fff006, 1'b0, 1'b0);
    chk(rd, 16'h0000);
    m.rd_word(28'h0fff010, 1'b0, 1'b0);
    chk(rd, 16'ha5c3);
    m.rd_word(28'h0fff011, 1'b0, 1'b0);
    outs(4'h9);
    chk(rd, 16'ha5c3);
    // status keeps the odd access until the write-only word clears it
    m.rd_word(28'h0fff004, 1'b0, 1'b0);
    chk(rd, 16'h0002);
    m.wr_word(28'h0fff006, 16'h0001);
    m.rd_word(28'h0fff004, 1'b0, 1'b0);
    chk(rd, 16'h0000);
    m.wr_word(28'h0fff000, 16'h0005);
    m.wr_word(28'h0fff002, 16'h0001);
    m.rd_word(28'h5fff010, 1'b1, 1'b1);
    outs(4'h8);
    chk(rd, 16'ha5c3);
    m.rd_word(28'h0fff010, 1'b0, 1'b1);
    outs(4'h2);
    m.rd_word(28'h5fff000, 1'b0, 1'b0);
    chk(rd, 16'h0005);
    m.rd_word(28'h5fff002, 1'b0, 1'b0);
    chk(rd, 16'h0001);
    rst();
    m.rd_word(28'h0fff000, 1'b0, 1'b0);
    outs(4'h8);
    chk(rd, {{(DATA_W-BASE_W){1'b0}}, BASE_RST});
    stop_test();
  end
endmodule
